//--- common/pgm_pkg.sv
package pgm_pkg;

    // Register map on the plain register port
    localparam logic [3:0] ADDR_PORT_DIR   = 4'h0;
    localparam logic [3:0] ADDR_PORT_LATCH = 4'h1;
    localparam logic [3:0] ADDR_MUX_CTRL   = 4'h2;
    localparam logic [3:0] ADDR_IRQ_SEL    = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EN     = 4'h4;

    localparam logic [7:0] PORT_DIR_RESET   = 8'h00;
    localparam logic [7:0] PORT_LATCH_RESET = 8'h00;
    localparam logic [7:0] MUX_CTRL_RESET   = 8'h00;
    localparam logic [7:0] IRQ_SEL_RESET    = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET     = 8'h00;

    // Field positions in the mux control register
    localparam int MUX_PWM_A_BIT   = 0;
    localparam int MUX_PWM_B_BIT   = 1;
    localparam int MUX_C1_RX_BIT   = 2;
    localparam int MUX_C1_TX_BIT   = 3;
    localparam int MUX_C1_CARD_BIT = 4;
    localparam int MUX_C3_RX_BIT   = 5;
    localparam int MUX_C3_TX_BIT   = 6;
    localparam int MUX_C3_CARD_BIT = 7;

    // Pin positions of the peripheral functions
    localparam int PIN_UART_TX = 0;
    localparam int PIN_UART_RX = 1;
    localparam int PIN_C1_TX   = 2;
    localparam int PIN_C1_RX   = 3;
    localparam int PIN_C3_TX   = 4;
    localparam int PIN_C3_RX   = 5;
    localparam int PIN_PWM_0   = 6;
    localparam int PIN_PWM_1   = 7;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pgm_bus_req_t;

    typedef struct packed {
        logic pwm_drive_a;
        logic pwm_drive_b;
        logic c1_rx_on;
        logic c1_tx_on;
        logic c1_card;
        logic c3_rx_on;
        logic c3_tx_on;
        logic c3_card;
        logic uart_on;
    } pgm_mux_sel_t;

    typedef struct packed {
        logic pwm_out_1;
        logic pwm_out_0;
        logic chan3_tx;
        logic chan3_rx_out;
        logic chan3_rx_oe;
        logic chan1_tx;
        logic chan1_rx_out;
        logic chan1_rx_oe;
        logic uart_tx;
    } pgm_periph_out_t;

endpackage : pgm_pkg

//--- core/pgm_pin_mux.sv
module pgm_pin_mux
    import pgm_pkg::*;
(
    // Selection and general port state
    input  wire pgm_mux_sel_t    sel,
    input  wire logic [7:0]      dir,
    input  wire logic [7:0]      latch,
    // Peripheral drive
    input  wire pgm_periph_out_t per,
    // Pin drive, enable active low
    output logic [7:0]           pin_out,
    output logic [7:0]           pin_oe_n
);

    function automatic logic [1:0] gen_pin(input logic d, input logic v);
        gen_pin = {v, ~d};
    endfunction : gen_pin

    logic [1:0] g [8];

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            g[i] = gen_pin(dir[i], latch[i]);  // [RULE1]
        end
        for (int i = 0; i < 8; i++) begin
            pin_out[i]  = g[i][1];
            pin_oe_n[i] = g[i][0];
        end
        // Overrides touch only their own pin; latch and direction stay intact [RULE14]
        if (sel.pwm_drive_b) begin  // [RULE5]
            pin_out[PIN_PWM_1]  = per.pwm_out_1;
            pin_oe_n[PIN_PWM_1] = 1'b0;
        end
        if (sel.pwm_drive_a) begin  // [RULE6]
            pin_out[PIN_PWM_0]  = per.pwm_out_0;
            pin_oe_n[PIN_PWM_0] = 1'b0;
        end
        if (sel.c3_rx_on) begin  // [RULE7]
            pin_out[PIN_C3_RX]  = per.chan3_rx_out;
            pin_oe_n[PIN_C3_RX] = sel.c3_card ? per.chan3_rx_oe : 1'b1;
        end
        if (sel.c3_tx_on && !sel.c3_card) begin  // [RULE8]
            pin_out[PIN_C3_TX]  = per.chan3_tx;
            pin_oe_n[PIN_C3_TX] = 1'b0;
        end
        if (sel.c1_rx_on) begin  // [RULE9]
            pin_out[PIN_C1_RX]  = per.chan1_rx_out;
            pin_oe_n[PIN_C1_RX] = sel.c1_card ? per.chan1_rx_oe : 1'b1;
        end
        if (sel.c1_tx_on && !sel.c1_card) begin  // [RULE10]
            pin_out[PIN_C1_TX]  = per.chan1_tx;
            pin_oe_n[PIN_C1_TX] = 1'b0;
        end
        if (sel.uart_on) begin
            pin_out[PIN_UART_RX]  = 1'b0;  // [RULE11]
            pin_oe_n[PIN_UART_RX] = 1'b1;
            pin_out[PIN_UART_TX]  = per.uart_tx;  // [RULE12]
            pin_oe_n[PIN_UART_TX] = 1'b0;
        end
    end

endmodule : pgm_pin_mux

//--- core/pgm_port5.sv
// Operation
// RULE1 - A general port pin drives out when its direction bit is 1 and is an input when 0.
// RULE2 - The direction register has eight write-only bits that reset to 0.
// RULE3 - The output latch holds the general output values and resets to 0.
// RULE4 - Reading the latch gives latch bits where direction is 1 and live pin levels where 0.
// RULE5 - Pin 7 is PWM output 1 when drive B is set, else the direction bit decides.
// RULE6 - Pin 6 is PWM output 0 when drive A is set, else the direction bit decides.
// RULE7 - Pin 5 is channel 3 receive when enabled, bidirectional in card mode, else general.
// RULE8 - Pin 4 is channel 3 transmit only with transmit on and card mode off, else general.
// RULE9 - Pin 3 is channel 1 receive when enabled, bidirectional in card mode, else general.
// RULE10 - Pin 2 is channel 1 transmit only with transmit on and card mode off, else general.
// RULE11 - Pin 1 is the FIFO UART receive input while that UART is on, else general.
// RULE12 - Pin 0 is the FIFO UART transmit output while that UART is on, else general.
// RULE13 - Pin n feeds external interrupt 8 plus n when its select is 0 and enable is 1.
// RULE14 - A peripheral overrides only its own pin and leaves latch and direction untouched.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
module pgm_port5
    import pgm_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic [7:0]      rdata,
    // Peripheral enables
    input  wire logic       uart_on,
    // Peripheral outputs toward pins
    input  wire logic       pwm_out_1,
    input  wire logic       pwm_out_0,
    input  wire logic       chan3_tx_pin,
    input  wire logic       chan3_rx_drive,
    input  wire logic       chan3_rx_oe_n,
    input  wire logic       chan1_tx_pin,
    input  wire logic       chan1_rx_drive,
    input  wire logic       chan1_rx_oe_n,
    input  wire logic       fifo_uart_tx_pin,
    // Pins
    input  wire logic [7:0] pin_in,
    output logic [7:0]      pin_out,
    output logic [7:0]      pin_oe_n,
    // Inputs to peripherals and interrupt controller
    output logic            chan3_rx_pin,
    output logic            chan1_rx_pin,
    output logic            fifo_uart_rx_pin,
    output logic [7:0]      ext_irq_n
);

    pgm_bus_req_t    req;
    pgm_mux_sel_t    sel;
    pgm_periph_out_t per;

    logic [7:0] port_dir_reg, port_dir_next;
    logic [7:0] port_latch_reg, port_latch_next;
    logic [7:0] mux_ctrl_reg, mux_ctrl_next;
    logic [7:0] irq_sel_reg, irq_sel_next;
    logic [7:0] irq_en_reg, irq_en_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] pin_out_reg, pin_oe_n_reg;
    logic [7:0] mux_out, mux_oe_n;
    logic [2:0] rx_in_reg, rx_in_next;
    logic [7:0] irq_reg, irq_next;

    assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

    assign sel = '{pwm_drive_a: mux_ctrl_reg[MUX_PWM_A_BIT],
                   pwm_drive_b: mux_ctrl_reg[MUX_PWM_B_BIT],
                   c1_rx_on:    mux_ctrl_reg[MUX_C1_RX_BIT],
                   c1_tx_on:    mux_ctrl_reg[MUX_C1_TX_BIT],
                   c1_card:     mux_ctrl_reg[MUX_C1_CARD_BIT],
                   c3_rx_on:    mux_ctrl_reg[MUX_C3_RX_BIT],
                   c3_tx_on:    mux_ctrl_reg[MUX_C3_TX_BIT],
                   c3_card:     mux_ctrl_reg[MUX_C3_CARD_BIT],
                   uart_on:     uart_on};

    assign per = '{pwm_out_1:    pwm_out_1,
                   pwm_out_0:    pwm_out_0,
                   chan3_tx:     chan3_tx_pin,
                   chan3_rx_out: chan3_rx_drive,
                   chan3_rx_oe:  chan3_rx_oe_n,
                   chan1_tx:     chan1_tx_pin,
                   chan1_rx_out: chan1_rx_drive,
                   chan1_rx_oe:  chan1_rx_oe_n,
                   uart_tx:      fifo_uart_tx_pin};

    pgm_pin_mux u_mux (
        .sel      (sel),
        .dir      (port_dir_reg),
        .latch    (port_latch_reg),
        .per      (per),
        .pin_out  (mux_out),
        .pin_oe_n (mux_oe_n)
    );

    // Register writes and read data
    always_comb begin
        port_dir_next   = port_dir_reg;
        port_latch_next = port_latch_reg;
        mux_ctrl_next   = mux_ctrl_reg;
        irq_sel_next    = irq_sel_reg;
        irq_en_next     = irq_en_reg;
        rdata_next      = 8'h00;
        if (req.wr) begin
            if (req.addr == ADDR_PORT_DIR) begin
                port_dir_next = req.wdata;  // [RULE2]
            end else if (req.addr == ADDR_PORT_LATCH) begin
                port_latch_next = req.wdata;  // [RULE3]
            end else if (req.addr == ADDR_MUX_CTRL) begin
                mux_ctrl_next = req.wdata;
            end else if (req.addr == ADDR_IRQ_SEL) begin
                irq_sel_next = req.wdata;
            end else if (req.addr == ADDR_IRQ_EN) begin
                irq_en_next = req.wdata;
            end
        end
        if (req.rd) begin
            // Direction is write-only and reads as zero, like unmapped space
            if (req.addr == ADDR_PORT_LATCH) begin
                rdata_next = (port_latch_reg & port_dir_reg)
                           | (pin_in & ~port_dir_reg);  // [RULE4]
            end else if (req.addr == ADDR_MUX_CTRL) begin
                rdata_next = mux_ctrl_reg;
            end else if (req.addr == ADDR_IRQ_SEL) begin
                rdata_next = irq_sel_reg;
            end else if (req.addr == ADDR_IRQ_EN) begin
                rdata_next = irq_en_reg;
            end
        end
    end

    // Input routing; pins keep feeding the port read path in parallel
    always_comb begin
        rx_in_next = {pin_in[PIN_C3_RX], pin_in[PIN_C1_RX], pin_in[PIN_UART_RX]};
        for (int i = 0; i < 8; i++) begin
            // Idle high when not routed, since the lines are active low
            irq_next[i] = (!irq_sel_reg[i] && irq_en_reg[i]) ? pin_in[i] : 1'b1;  // [RULE13]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_dir_reg   <= PORT_DIR_RESET;
            port_latch_reg <= PORT_LATCH_RESET;
            mux_ctrl_reg   <= MUX_CTRL_RESET;
            irq_sel_reg    <= IRQ_SEL_RESET;
            irq_en_reg     <= IRQ_EN_RESET;
            rdata_reg      <= 8'h00;
            pin_out_reg    <= 8'h00;
            pin_oe_n_reg   <= 8'hFF;
            rx_in_reg      <= 3'h7;
            irq_reg        <= 8'hFF;
        end else begin
            port_dir_reg   <= port_dir_next;
            port_latch_reg <= port_latch_next;
            mux_ctrl_reg   <= mux_ctrl_next;
            irq_sel_reg    <= irq_sel_next;
            irq_en_reg     <= irq_en_next;
            rdata_reg      <= rdata_next;
            // Registered pin drive adds one cycle of latency after a write
            pin_out_reg    <= mux_out;
            pin_oe_n_reg   <= mux_oe_n;
            rx_in_reg      <= rx_in_next;
            irq_reg        <= irq_next;
        end
    end

    assign rdata            = rdata_reg;
    assign pin_out          = pin_out_reg;
    assign pin_oe_n         = pin_oe_n_reg;
    assign chan3_rx_pin     = rx_in_reg[2];
    assign chan1_rx_pin     = rx_in_reg[1];
    assign fifo_uart_rx_pin = rx_in_reg[0];
    assign ext_irq_n        = irq_reg;

endmodule : pgm_port5

//--- tb/pgm_pin_model.sv
module pgm_pin_model
    import pgm_pkg::*;
(
    // Design side of the pins
    input  wire logic [7:0]      pin_out,
    input  wire logic [7:0]      pin_oe_n,
    // Outside world and peripherals
    input  wire logic [7:0]      ext_drive,
    input  wire pgm_periph_out_t per_val,
    output logic [7:0]           pin_in,
    output pgm_periph_out_t      per
);
    timeunit 1ns;
    timeprecision 1ps;
    // Outside drivers back off where the port drives, so contention is never seen
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
    assign per    = per_val;
endmodule : pgm_pin_model

//--- tb/pgm_port5_bench.sv
module pgm_port5_bench
    import pgm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic            ref_clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, uart_on = 1'b0;
    logic [3:0]      addr = 4'h0;
    logic [7:0]      wdata = 8'h00, ext_drive = 8'h5A, rd_val;
    logic [7:0]      rdata, pin_in, pin_out, pin_oe_n, ext_irq_n;
    logic            chan3_rx_pin, chan1_rx_pin, fifo_uart_rx_pin;
    // Card receive enables held active so card mode shows as a driven pin
    pgm_periph_out_t per, per_val = 9'h1ED;
    int              miscompares = 0, check_count = 0;
    logic [7:0]      tmux[12] = '{8'h00, 8'h03, 8'h20, 8'hA0, 8'h40, 8'hC0,
                                  8'h04, 8'h14, 8'h08, 8'h18, 8'h00, 8'h00};
    logic [7:0]      toe[12]  = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00,
                                  8'h08, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    logic [7:0]      tout[12] = '{8'h00, 8'hC0, 8'h00, 8'h20, 8'h10, 8'h00,
                                  8'h00, 8'h08, 8'h04, 8'h00, 8'h01, 8'h00};

    always #4 ref_clk = ~ref_clk;

    pgm_pin_model u_pgm_pin_model (
        .pin_out   (pin_out),
        .pin_oe_n  (pin_oe_n),
        .ext_drive (ext_drive),
        .per_val   (per_val),
        .pin_in    (pin_in),
        .per       (per)
    );

    pgm_port5 u_pgm_port5 (
        .ref_clk          (ref_clk),
        .reset_n          (reset_n),
        .addr             (addr),
        .wdata            (wdata),
        .wr_en            (wr_en),
        .rd_en            (rd_en),
        .rdata            (rdata),
        .uart_on          (uart_on),
        .pwm_out_1        (per.pwm_out_1),
        .pwm_out_0        (per.pwm_out_0),
        .chan3_tx_pin     (per.chan3_tx),
        .chan3_rx_drive   (per.chan3_rx_out),
        .chan3_rx_oe_n    (per.chan3_rx_oe),
        .chan1_tx_pin     (per.chan1_tx),
        .chan1_rx_drive   (per.chan1_rx_out),
        .chan1_rx_oe_n    (per.chan1_rx_oe),
        .fifo_uart_tx_pin (per.uart_tx),
        .pin_in           (pin_in),
        .pin_out          (pin_out),
        .pin_oe_n         (pin_oe_n),
        .chan3_rx_pin     (chan3_rx_pin),
        .chan1_rx_pin     (chan1_rx_pin),
        .fifo_uart_rx_pin (fifo_uart_rx_pin),
        .ext_irq_n        (ext_irq_n)
    );

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        rd_val = rdata;
    endtask : rd

    // Registered mux adds a cycle after the register lands
    task settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    task final_report;
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        #20000;
        miscompares++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(ADDR_PORT_DIR);
        chk("dir read", rd_val, PORT_DIR_RESET);
        rd(ADDR_PORT_LATCH);
        chk("latch read", rd_val, 8'h5A);
        chk("oe reset", pin_oe_n, 8'hFF);
        wr(ADDR_PORT_DIR, 8'hF0);
        wr(ADDR_PORT_LATCH, 8'hA5);
        wr(4'hF, 8'hFF);
        rd(ADDR_PORT_LATCH);
        chk("latch mixed", rd_val, 8'hAA);
        chk("oe mixed", pin_oe_n, 8'h0F);
        chk("out mixed", pin_out & 8'hF0, 8'hA0);
        rd(ADDR_PORT_DIR);
        chk("dir write only", rd_val, 8'h00);
        rd(4'hF);
        chk("unmapped", rd_val, 8'h00);
        wr(ADDR_PORT_DIR, 8'hFF);
        wr(ADDR_PORT_LATCH, 8'h00);
        for (int i = 0; i < 12; i++) begin
            @(posedge ref_clk);
            uart_on <= tmux[i] == 8'h00 && toe[i] == 8'h02;
            wr(ADDR_MUX_CTRL, tmux[i]);
            settle();
            chk("mux oe", pin_oe_n, toe[i]);
            chk("mux out", pin_out & ~pin_oe_n, tout[i]);
        end
        wr(ADDR_PORT_DIR, 8'h00);
        wr(ADDR_IRQ_SEL, 8'h0F);
        wr(ADDR_IRQ_EN, 8'h33);
        settle();
        chk("irq high", ext_irq_n, 8'hDF);
        chk("rx high", {5'h00, chan3_rx_pin, chan1_rx_pin, fifo_uart_rx_pin}, 8'h03);
        @(posedge ref_clk);
        ext_drive <= 8'h00;
        settle();
        chk("irq low", ext_irq_n, 8'hCF);
        chk("rx low", {5'h00, chan3_rx_pin, chan1_rx_pin, fifo_uart_rx_pin}, 8'h00);
        final_report();
    end
endmodule : pgm_port5_bench

//--- tb/pgm_port5_checker.sv
module pgm_port5_checker
    import pgm_pkg::*;
(
    input wire logic       ref_clk, reset_n, wr_en, rd_en, uart_on, fifo_uart_rx_pin,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata, rdata, pin_in, pin_out, pin_oe_n, ext_irq_n,
    input wire logic       pwm_out_1, pwm_out_0, chan3_tx_pin, chan3_rx_drive, chan3_rx_oe_n,
    input wire logic       chan1_tx_pin, chan1_rx_drive, chan1_rx_oe_n, fifo_uart_tx_pin,
    input wire logic       chan3_rx_pin, chan1_rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] dir_reg, lat_reg, mux_reg, sel_reg, en_reg, oe_reg, out_reg;
    logic [7:0] oe_next, out_next, irq_next, pin_ok;

    // Pin out is only judged where the pin drives
    assign pin_ok = ~(pin_oe_n ^ oe_reg) & (oe_reg | ~(pin_out ^ out_reg));

    always_comb begin
        oe_next  = ~dir_reg;
        out_next = lat_reg;
        if (mux_reg[MUX_PWM_B_BIT]) begin
            oe_next[7]  = 1'b0;
            out_next[7] = pwm_out_1;
        end
        if (mux_reg[MUX_PWM_A_BIT]) begin
            oe_next[6]  = 1'b0;
            out_next[6] = pwm_out_0;
        end
        if (mux_reg[MUX_C3_RX_BIT]) begin
            oe_next[5]  = ~mux_reg[MUX_C3_CARD_BIT] | chan3_rx_oe_n;
            out_next[5] = chan3_rx_drive;
        end
        if (mux_reg[MUX_C3_TX_BIT] && !mux_reg[MUX_C3_CARD_BIT]) begin
            oe_next[4]  = 1'b0;
            out_next[4] = chan3_tx_pin;
        end
        if (mux_reg[MUX_C1_RX_BIT]) begin
            oe_next[3]  = ~mux_reg[MUX_C1_CARD_BIT] | chan1_rx_oe_n;
            out_next[3] = chan1_rx_drive;
        end
        if (mux_reg[MUX_C1_TX_BIT] && !mux_reg[MUX_C1_CARD_BIT]) begin
            oe_next[2]  = 1'b0;
            out_next[2] = chan1_tx_pin;
        end
        if (uart_on) begin
            oe_next[1:0] = 2'h2;
            out_next[0]  = fifo_uart_tx_pin;
        end
        irq_next = ~(~sel_reg & en_reg) | pin_in;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {dir_reg, lat_reg, mux_reg, sel_reg, en_reg, out_reg} <= '0;
            oe_reg <= 8'hFF;
        end else begin
            if (wr_en && addr == ADDR_PORT_DIR) dir_reg <= wdata;
            if (wr_en && addr == ADDR_PORT_LATCH) lat_reg <= wdata;
            if (wr_en && addr == ADDR_MUX_CTRL) mux_reg <= wdata;
            if (wr_en && addr == ADDR_IRQ_SEL) sel_reg <= wdata;
            if (wr_en && addr == ADDR_IRQ_EN) en_reg <= wdata;
            oe_reg  <= oe_next;
            out_reg <= out_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_PWM_PINS: assert property (&pin_ok[7:6])
        else $error("pwm pin drive wrong");
    AST_CH3_PINS: assert property (&pin_ok[5:4])
        else $error("ch3 pin drive wrong");
    AST_CH1_PINS: assert property (&pin_ok[3:2])
        else $error("ch1 pin drive wrong");
    AST_UART_PINS: assert property (&pin_ok[1:0])
        else $error("uart pin drive wrong");
    AST_GPIO_DIR: assert property ((mux_reg == 8'h00 && !uart_on) [*2] |->
        pin_oe_n == ~$past(dir_reg)) else $error("general direction wrong");
    AST_LATCH_OUT: assert property ((mux_reg == 8'h00 && !uart_on) [*2] |->
        (pin_out & ~pin_oe_n) == ($past(lat_reg) & $past(dir_reg)))
        else $error("latch drive wrong");
    AST_DIR_READ: assert property (rd_en && addr == ADDR_PORT_DIR |=> rdata == 8'h00)
        else $error("direction read not zero");
    AST_LATCH_READ: assert property (rd_en && addr == ADDR_PORT_LATCH |=> rdata ==
        (($past(lat_reg) & $past(dir_reg)) | ($past(pin_in) & ~$past(dir_reg))))
        else $error("latch read wrong");
    AST_RD_IDLE: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("rdata not idle");
    AST_IRQ_ROUTE: assert property (ext_irq_n == $past(irq_next))
        else $error("irq route wrong");
    AST_CH_RX_COPY: assert property (1'b1 |=>
        {chan3_rx_pin, chan1_rx_pin} == {$past(pin_in[5]), $past(pin_in[3])})
        else $error("serial rx copy wrong");
    AST_RX_COPY: assert property (uart_on |=> fifo_uart_rx_pin == $past(pin_in[1]))
        else $error("uart rx copy wrong");

    CVR_CARD: cover property (mux_reg[MUX_C3_CARD_BIT] && mux_reg[MUX_C3_RX_BIT] && !pin_oe_n[5]);
    CVR_UART: cover property (uart_on && !pin_oe_n[0]);
    CVR_IRQ: cover property (ext_irq_n != 8'hFF);
endmodule : pgm_port5_checker

bind pgm_port5 pgm_port5_checker u_pgm_port5_checker (.*);
